/* File: bench/mac_drv.sv */
// MAC-side register master model
`timescale 1ns/100ps
module mac_drv (
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [4:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  // One-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // One-cycle read, data taken in the next cycle
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
endmodule : mac_drv

/* File: bench/virtual_phy_autoneg_control_tb.sv */
// Self-checking bench for the emulated PHY control block
`timescale 1ns/100ps
module virtual_phy_autoneg_control_tb;
  logic sys_clk = 1'b0, srst = 1'b1, mac = 1'b0, ext = 1'b0;
  logic [4:0] a;
  logic [15:0] wd, rdat, q;
  logic wr, rd, spd, fd, tx, rx, busy;
  logic miim = 1'b0, reload = 1'b0;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  // Rows: control word, MAC mode, duplex pin, expected full duplex
  logic [18:0] rows [5] = '{{16'h0000, 3'b000}, {16'h0100, 3'b001},
    {16'h1000, 3'b101}, {16'h1000, 3'b110}, {16'h0100, 3'b111}};
  always #2.5 sys_clk = ~sys_clk;
  mac_drv u_mac (.sys_clk(sys_clk), .reg_rdata(rdat), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd));
  virtual_phy_autoneg_control #(.RST_HOLD_CYCLES(64)) DUT (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_from_miim(miim),
    .reg_rdata(rdat), .mac_mode(mac), .ext_duplex_indicator(ext), .duplex_pol_strap(1'b0),
    .speed_strap(1'b0), .digital_reset(1'b0), .eeprom_reload(reload), .port0_speed_100(spd),
    .port0_full_duplex(fd), .port0_tx_pause(tx), .port0_rx_pause(rx), .neg_busy(busy));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t mismatch %h vs %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Cycle ceiling against hangs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    u_mac.rd(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, q);
    chk(q, vphy_emul_pkg::BASIC_CONTROL_RST);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk) {mac, ext} <= rows[i][2:1];
      u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, rows[i][18:3]);
      repeat (4) @(posedge sys_clk);
      #1 chk(fd, rows[i][0]);
    end
    mac <= 1'b0;
    u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, 16'h2000);
    repeat (4) @(posedge sys_clk);
    #1 chk(spd, 1'b1);
    u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, 16'h8000);
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(posedge sys_clk);
    u_mac.rd(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, q);
    chk(q, vphy_emul_pkg::BASIC_CONTROL_RST);
    // Run after reset: partner offers 10 Mbps half duplex only
    repeat (8) @(posedge sys_clk);
    u_mac.rd(vphy_emul_pkg::NEG_EXPANSION_REG, q);
    chk(q, 16'h0003);
    u_mac.rd(vphy_emul_pkg::PARTNER_ABILITY_REG, q);
    chk(q, 16'h0c21);
    u_mac.rd(vphy_emul_pkg::EMUL_BASIC_STATUS_REG, q);
    chk(q, 16'h0028);
    #1 chk({spd, fd}, 2'b00);
    // No common ability: parallel detect
    u_mac.wr(vphy_emul_pkg::ADVERTISEMENT_REG, 16'h0181);
    u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, 16'h1200);
    repeat (8) @(posedge sys_clk);
    u_mac.rd(vphy_emul_pkg::NEG_EXPANSION_REG, q);
    chk(q, 16'h0002);
    u_mac.rd(vphy_emul_pkg::PARTNER_ABILITY_REG, q);
    chk(q, 16'h0021);
    #1 chk({spd, fd}, 2'b00);
    // Full duplex partner with symmetric pause
    @(posedge sys_clk) ext <= 1'b0;
    u_mac.wr(vphy_emul_pkg::ADVERTISEMENT_REG, 16'h0c61);
    u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, 16'h1200);
    repeat (8) @(posedge sys_clk);
    #1 chk({fd, tx, rx}, 3'b111);
    // Manual pause override
    u_mac.wr(vphy_emul_pkg::PORT0_MANUAL_PAUSE, 16'h0004);
    repeat (2) @(posedge sys_clk);
    #1 chk({tx, rx}, 2'b00);
    u_mac.rd(vphy_emul_pkg::PORT0_MANUAL_PAUSE, q);
    chk(q, 16'h000c);
    u_mac.rd(vphy_emul_pkg::ADVERTISEMENT_REG, q);
    chk(q, 16'h0c61);
    // MII management blocked in MAC mode
    @(posedge sys_clk) {mac, miim} <= 2'b11;
    u_mac.wr(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, 16'h0000);
    u_mac.rd(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, q);
    chk(q, 16'h0000);
    @(posedge sys_clk) miim <= 1'b0;
    u_mac.rd(vphy_emul_pkg::EMUL_BASIC_CONTROL_REG, q);
    chk(q, 16'h1000);
    @(posedge sys_clk) mac <= 1'b0;
    // Reload restarts negotiation
    @(posedge sys_clk) reload <= 1'b1;
    @(posedge sys_clk) reload <= 1'b0;
    #1 chk(busy, 1'b1);
    // Chip reset bit holds, clears itself, restores defaults
    u_mac.wr(vphy_emul_pkg::CHIP_RESET_CONTROL, 16'h0001);
    u_mac.rd(vphy_emul_pkg::CHIP_RESET_CONTROL, q);
    chk(q, 16'h0001);
    repeat (80) @(posedge sys_clk);
    u_mac.rd(vphy_emul_pkg::CHIP_RESET_CONTROL, q);
    chk(q, 16'h0000);
    u_mac.rd(vphy_emul_pkg::ADVERTISEMENT_REG, q);
    chk(q, vphy_emul_pkg::ADVERTISEMENT_RST);
    final_report();
  end
endmodule : virtual_phy_autoneg_control_tb

/* File: hdl/virtual_phy_autoneg_control.sv */
// Emulated PHY negotiation, forcing, pause resolution and soft resets for port 0
//
// How it works
// - No common ability: fail, clear able, half.
// - Fallback speed comes from speed strap.
// - Fallback sets exactly one partner technology bit.
// - Negotiation off forces speed and duplex bits.
// - Negotiation on ignores forced speed, duplex.
// - Advertise pause bits, resolve by standard rules.
// - Partner asym pause mirrors advertisement; partner sym set if either bit is.
// - Manual pause used if negotiation off or selected.
// - Manual pause register reads active settings.
// - Manual pause writes leave advertisement untouched.
// - MAC mode duplex: pin equals polarity strap.
// - MAC mode duplex tracks pin, never latched.
// - MAC mode, negotiation off: duplex bit rules.
// - MAC mode blocks MII management register access.
// - Chip reset bit resets, self-clears after 102us.
// - Basic reset bit resets, then reads zero.
// - Priority 100FD, 100HD, 10FD, 10HD.
// - Any reset, restart, reload reruns negotiation.
// - Set complete, then page received, then result.
// - Success sets able, loads partner abilities.
`timescale 1ns/100ps
module virtual_phy_autoneg_control #(
  parameter int unsigned RST_HOLD_CYCLES = vphy_emul_pkg::EMUL_RST_HOLD_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_from_miim,
  output logic      [15:0] reg_rdata,
  input  wire logic        mac_mode,
  input  wire logic        ext_duplex_indicator,
  input  wire logic        duplex_pol_strap,
  input  wire logic        speed_strap,
  input  wire logic        digital_reset,
  input  wire logic        eeprom_reload,
  output logic             port0_speed_100,
  output logic             port0_full_duplex,
  output logic             port0_tx_pause,
  output logic             port0_rx_pause,
  output logic             neg_busy
);

  // Width of the chip reset hold counter
  localparam int unsigned HOLD_W = $clog2(RST_HOLD_CYCLES + 1);
  // Last count of the hold, where the self-clearing bit drops
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_HOLD_CYCLES - 1);
  // Basic control bits that software can store; reset and restart are strobes
  localparam logic [15:0] CTL_KEEP_MASK =
    (16'h0001 << vphy_emul_pkg::SPEED_SELECT_LSB) |
    (16'h0001 << vphy_emul_pkg::NEG_ENABLE_BIT) |
    (16'h0001 << vphy_emul_pkg::DUPLEX_MODE_BIT);
  // Advertisement bits that software can store; the selector is fixed
  localparam logic [15:0] ADV_KEEP_MASK =
    (16'h0001 << vphy_emul_pkg::ABIL_10HD_BIT) |
    (16'h0001 << vphy_emul_pkg::ABIL_10FD_BIT) |
    (16'h0001 << vphy_emul_pkg::ABIL_100HD_BIT) |
    (16'h0001 << vphy_emul_pkg::ABIL_100FD_BIT) |
    (16'h0001 << vphy_emul_pkg::ABIL_SYM_PAUSE_BIT) |
    (16'h0001 << vphy_emul_pkg::ABIL_ASYM_PAUSE_BIT);

  // Technology bits of an ability word, ordered {100FD, 100HD, 10FD, 10HD}
  function automatic logic [3:0] tech_of(input logic [15:0] word);
    return {word[vphy_emul_pkg::ABIL_100FD_BIT], word[vphy_emul_pkg::ABIL_100HD_BIT],
            word[vphy_emul_pkg::ABIL_10FD_BIT], word[vphy_emul_pkg::ABIL_10HD_BIT]};
  endfunction : tech_of

  // Builds an emulated partner ability word from technology and pause bits
  function automatic logic [15:0] partner_word(
    input logic [3:0] tech,
    input logic       psym,
    input logic       pasym
  );
    logic [15:0] word;
    word = vphy_emul_pkg::ABIL_SELECTOR;
    word[vphy_emul_pkg::ABIL_100FD_BIT]      = tech[3];
    word[vphy_emul_pkg::ABIL_100HD_BIT]      = tech[2];
    word[vphy_emul_pkg::ABIL_10FD_BIT]       = tech[1];
    word[vphy_emul_pkg::ABIL_10HD_BIT]       = tech[0];
    word[vphy_emul_pkg::ABIL_SYM_PAUSE_BIT]  = psym;
    word[vphy_emul_pkg::ABIL_ASYM_PAUSE_BIT] = pasym;
    return word;
  endfunction : partner_word

  // Highest common mode: {found, speed_100, full}
  function automatic logic [2:0] pick_best(input logic [3:0] common);
    logic [2:0] best;
    best = 3'b000;
    // Priority order from the fastest full duplex down
    if (common[3]) begin
      best = 3'b111;
    end else if (common[2]) begin
      best = 3'b110;
    end else if (common[1]) begin
      best = 3'b101;
    end else if (common[0]) begin
      best = 3'b100;
    end
    return best;
  endfunction : pick_best

  // Standard pause resolution, result {tx, rx}
  function automatic logic [1:0] pause_resolve(
    input logic lsym,
    input logic lasym,
    input logic psym,
    input logic pasym
  );
    logic tx;
    logic rx;
    tx = (lsym & psym) | (~lsym & lasym & psym & pasym);
    rx = (lsym & psym) | (lsym & lasym & ~psym & pasym);
    return {tx, rx};
  endfunction : pause_resolve

  // Register file state
  logic [15:0]       ctl;            // Stored basic control bits
  logic [15:0]       next_ctl;
  logic [15:0]       adv;            // Advertisement word
  logic [15:0]       next_adv;
  logic [2:0]        mp;             // Manual pause {select, rx, tx}
  logic [2:0]        next_mp;
  logic              chip_rst_bit;   // Self-clearing chip reset request
  logic              next_chip_rst;
  logic [HOLD_W-1:0] hold_cnt;       // Cycles spent in the chip reset hold
  logic [HOLD_W-1:0] next_hold;
  // Negotiation state
  vphy_emul_pkg::neg_state_t state;  // Sequencer state
  vphy_emul_pkg::neg_state_t next_state;
  logic              neg_done;       // Negotiation complete status
  logic              next_done;
  logic              page_rcvd;      // Page received expansion bit
  logic              next_page;
  logic              partner_able;   // Partner negotiation able flag
  logic              next_able;
  logic [15:0]       partner;        // Emulated partner ability word
  logic [15:0]       next_partner;
  logic              res_speed;      // Resolved 100 Mbps
  logic              next_res_speed;
  logic              res_full;       // Resolved full duplex
  logic              next_res_full;
  logic              res_tx;         // Resolved transmit pause
  logic              next_res_tx;
  logic              res_rx;         // Resolved receive pause
  logic              next_res_rx;
  // Output next values
  logic              next_speed;
  logic              next_full;
  logic              next_tx;
  logic              next_rx;
  logic [15:0]       next_rdata;
  // Decode and helper nets
  logic              bus_open;       // Access allowed from this path
  logic              wr_ok;
  logic              rd_ok;
  logic              wr_ctl;
  logic              wr_adv;
  logic              wr_mp;
  logic              wr_crc;
  logic              basic_rst;      // Basic control reset strobe
  logic              block_rst;      // Any reset of the register fields
  logic              neg_rerun;      // Any event that restarts negotiation
  logic              strap_full;     // Partner full duplex from pin and strap
  logic [3:0]        strap_tech;     // Partner technology from straps
  logic              p_sym;          // Partner symmetric pause
  logic              p_asym;         // Partner asymmetric pause
  logic [2:0]        best;           // Best common mode
  logic              neg_en;         // Negotiation enable bit
  logic              manual_sel;     // Manual pause in charge

  // MII management cannot reach the registers in MAC mode
  assign bus_open  = !(mac_mode && reg_from_miim);
  assign wr_ok     = reg_wr && bus_open;
  assign rd_ok     = reg_rd && bus_open;
  assign wr_ctl    = wr_ok && (reg_addr == vphy_emul_pkg::EMUL_BASIC_CONTROL_REG);
  assign wr_adv    = wr_ok && (reg_addr == vphy_emul_pkg::ADVERTISEMENT_REG);
  assign wr_mp     = wr_ok && (reg_addr == vphy_emul_pkg::PORT0_MANUAL_PAUSE);
  assign wr_crc    = wr_ok && (reg_addr == vphy_emul_pkg::CHIP_RESET_CONTROL);
  // Reset strobe acts at once, so the bit never reads back as one
  assign basic_rst = wr_ctl && reg_wdata[vphy_emul_pkg::EMUL_SOFT_RESET_BIT];
  // Register fields are held at defaults for the whole chip reset hold
  assign block_rst = srst || basic_rst || chip_rst_bit;
  // Every restart source returns the sequencer to its first step
  assign neg_rerun = block_rst || digital_reset || eeprom_reload ||
                     (wr_ctl && reg_wdata[vphy_emul_pkg::RESTART_NEG_BIT]);
  // Partner abilities: speeds up to the strap, full duplex when pin matches
  assign strap_full = (ext_duplex_indicator == duplex_pol_strap);
  assign strap_tech = speed_strap ? {strap_full, 1'b1, strap_full, 1'b1}
                                  : {2'b00, strap_full, 1'b1};
  // Partner pause mirrors the request so that it is always accepted
  assign p_sym  = adv[vphy_emul_pkg::ABIL_SYM_PAUSE_BIT] |
                  adv[vphy_emul_pkg::ABIL_ASYM_PAUSE_BIT];
  assign p_asym = adv[vphy_emul_pkg::ABIL_ASYM_PAUSE_BIT];
  assign best   = pick_best(tech_of(adv) & strap_tech);
  assign neg_en = ctl[vphy_emul_pkg::NEG_ENABLE_BIT];
  // Manual pause rules when negotiation is off or when selected
  assign manual_sel = !neg_en || mp[vphy_emul_pkg::MP_SELECT_BIT];
  // Busy while the sequencer has steps left
  assign neg_busy = (state != vphy_emul_pkg::NEG_IDLE);

  // Register file next values
  always_comb begin
    next_ctl      = ctl;
    next_adv      = adv;
    next_mp       = mp;
    next_chip_rst = chip_rst_bit;
    next_hold     = hold_cnt;
    // Chip reset hold counts out, then the bit clears itself
    if (chip_rst_bit) begin
      if (hold_cnt == HOLD_LAST) begin
        next_chip_rst = 1'b0;
        next_hold     = '0;
      end else begin
        next_hold = hold_cnt + 1'b1;
      end
    end else if (wr_crc && reg_wdata[vphy_emul_pkg::CRC_EMUL_RST_BIT]) begin
      next_chip_rst = 1'b1;
      next_hold     = '0;
    end
    // Only speed, enable and duplex are stored
    if (wr_ctl) begin
      next_ctl = reg_wdata & CTL_KEEP_MASK;
    end
    // Advertisement keeps its selector code
    if (wr_adv) begin
      next_adv = (reg_wdata & ADV_KEEP_MASK) | vphy_emul_pkg::ABIL_SELECTOR;
    end
    // Manual pause writes touch nothing but their own field
    if (wr_mp) begin
      next_mp = {reg_wdata[vphy_emul_pkg::MP_SELECT_BIT], reg_wdata[vphy_emul_pkg::MP_RX_BIT],
                 reg_wdata[vphy_emul_pkg::MP_TX_BIT]};
    end
    // Soft and hard resets restore the control, advertisement and manual pause fields
    if (block_rst) begin
      next_ctl = vphy_emul_pkg::BASIC_CONTROL_RST;
      next_adv = vphy_emul_pkg::ADVERTISEMENT_RST;
      next_mp  = vphy_emul_pkg::MANUAL_PAUSE_RST;
    end
    // Apart from counting out, the hold ends only on a hard reset
    if (srst) begin
      next_chip_rst = 1'b0;
      next_hold     = '0;
    end
  end

  // Register file flip-flops
  always_ff @(posedge sys_clk) begin
    ctl          <= next_ctl;
    adv          <= next_adv;
    mp           <= next_mp;
    chip_rst_bit <= next_chip_rst;
    hold_cnt     <= next_hold;
  end

  // Negotiation sequencer next values
  always_comb begin
    next_state     = state;
    next_done      = neg_done;
    next_page      = page_rcvd;
    next_able      = partner_able;
    next_partner   = partner;
    next_res_speed = res_speed;
    next_res_full  = res_full;
    next_res_tx    = res_tx;
    next_res_rx    = res_rx;
    unique case (state)
      // Nothing to do until a restart
      vphy_emul_pkg::NEG_IDLE: begin
        next_state = vphy_emul_pkg::NEG_IDLE;
      end
      // First step: complete status
      vphy_emul_pkg::NEG_COMPLETE: begin
        next_done  = 1'b1;
        next_state = vphy_emul_pkg::NEG_PAGE;
      end
      // Second step: page received
      vphy_emul_pkg::NEG_PAGE: begin
        next_page  = 1'b1;
        next_state = vphy_emul_pkg::NEG_RESOLVE;
      end
      // Last step: register the result
      vphy_emul_pkg::NEG_RESOLVE: begin
        next_state = vphy_emul_pkg::NEG_IDLE;
        if (best[2]) begin
          // Common mode found: partner is able and shows its abilities
          next_able      = 1'b1;
          next_partner   = partner_word(strap_tech, p_sym, p_asym);
          next_res_speed = best[1];
          next_res_full  = best[0];
          // Pause only applies to a full duplex link
          if (best[0]) begin
            {next_res_tx, next_res_rx} = pause_resolve(adv[vphy_emul_pkg::ABIL_SYM_PAUSE_BIT],
              adv[vphy_emul_pkg::ABIL_ASYM_PAUSE_BIT], p_sym, p_asym);
          end else begin
            next_res_tx = 1'b0;
            next_res_rx = 1'b0;
          end
        end else begin
          // Parallel detect: failed, half duplex, speed from strap
          next_able      = 1'b0;
          next_res_full  = 1'b0;
          next_res_speed = speed_strap;
          next_res_tx    = 1'b0;
          next_res_rx    = 1'b0;
          // Exactly one half duplex bit names the detected mode
          next_partner = partner_word(speed_strap ? 4'b0100 : 4'b0001, p_sym, p_asym);
        end
      end
    endcase
    // Any restart source begins a fresh run
    if (neg_rerun) begin
      next_state = vphy_emul_pkg::NEG_COMPLETE;
      next_done  = 1'b0;
      next_page  = 1'b0;
      next_able  = 1'b0;
    end
    // Resets bring back the strap-derived partner word
    if (block_rst) begin
      next_partner   = partner_word(strap_tech, p_sym, p_asym);
      next_res_speed = 1'b0;
      next_res_full  = 1'b0;
      next_res_tx    = 1'b0;
      next_res_rx    = 1'b0;
    end
  end

  // Negotiation flip-flops
  always_ff @(posedge sys_clk) begin
    state        <= next_state;
    neg_done     <= next_done;
    page_rcvd    <= next_page;
    partner_able <= next_able;
    partner      <= next_partner;
    res_speed    <= next_res_speed;
    res_full     <= next_res_full;
    res_tx       <= next_res_tx;
    res_rx       <= next_res_rx;
  end

  // Port settings and read data next values
  always_comb begin
    // Speed: forced when negotiation is off, resolved otherwise
    next_speed = neg_en ? res_speed : ctl[vphy_emul_pkg::SPEED_SELECT_LSB];
    if (mac_mode) begin
      // Pin compared with strap every cycle, never latched
      next_full = neg_en ? strap_full : ctl[vphy_emul_pkg::DUPLEX_MODE_BIT];
    end else begin
      next_full = neg_en ? res_full : ctl[vphy_emul_pkg::DUPLEX_MODE_BIT];
    end
    // Pause from the manual register or from the resolution
    next_tx = manual_sel ? mp[vphy_emul_pkg::MP_TX_BIT] : res_tx;
    next_rx = manual_sel ? mp[vphy_emul_pkg::MP_RX_BIT] : res_rx;
    // Read data stand for the one cycle after the strobe
    next_rdata = 16'h0000;
    if (rd_ok) begin
      case (reg_addr)
        vphy_emul_pkg::EMUL_BASIC_CONTROL_REG: begin
          next_rdata = ctl;
        end
        vphy_emul_pkg::EMUL_BASIC_STATUS_REG: begin
          next_rdata[vphy_emul_pkg::STAT_NEG_ABLE_BIT] = 1'b1;
          next_rdata[vphy_emul_pkg::STAT_NEG_DONE_BIT] = neg_done;
        end
        vphy_emul_pkg::ADVERTISEMENT_REG: begin
          next_rdata = adv;
        end
        vphy_emul_pkg::PARTNER_ABILITY_REG: begin
          next_rdata = partner;
        end
        vphy_emul_pkg::NEG_EXPANSION_REG: begin
          next_rdata[vphy_emul_pkg::EXP_PARTNER_ABLE_BIT] = partner_able;
          next_rdata[vphy_emul_pkg::EXP_PAGE_RCVD_BIT]    = page_rcvd;
        end
        vphy_emul_pkg::PORT0_MANUAL_PAUSE: begin
          next_rdata[vphy_emul_pkg::MP_TX_BIT]     = mp[vphy_emul_pkg::MP_TX_BIT];
          next_rdata[vphy_emul_pkg::MP_RX_BIT]     = mp[vphy_emul_pkg::MP_RX_BIT];
          next_rdata[vphy_emul_pkg::MP_SELECT_BIT] = mp[vphy_emul_pkg::MP_SELECT_BIT];
          next_rdata[vphy_emul_pkg::MP_ACT_FD_BIT] = port0_full_duplex;
          next_rdata[vphy_emul_pkg::MP_ACT_TX_BIT] = port0_tx_pause;
          next_rdata[vphy_emul_pkg::MP_ACT_RX_BIT] = port0_rx_pause;
        end
        vphy_emul_pkg::CHIP_RESET_CONTROL: begin
          next_rdata[vphy_emul_pkg::CRC_EMUL_RST_BIT] = chip_rst_bit;
        end
        // Unmapped addresses read as zero
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
    // Hard reset clears every registered output; neg_busy rises as the sequencer restarts
    if (srst) begin
      next_speed = 1'b0;
      next_full  = 1'b0;
      next_tx    = 1'b0;
      next_rx    = 1'b0;
      next_rdata = 16'h0000;
    end
  end

  // Output flip-flops
  always_ff @(posedge sys_clk) begin
    port0_speed_100   <= next_speed;
    port0_full_duplex <= next_full;
    port0_tx_pause    <= next_tx;
    port0_rx_pause    <= next_rx;
    reg_rdata         <= next_rdata;
  end

  // Failed run leaves half duplex and a cleared able flag
  a_fail_half_duplex: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state == vphy_emul_pkg::NEG_RESOLVE && !best[2] && !neg_rerun)
      |=> (!partner_able && !res_full)
  ) else $error("Failed negotiation kept full duplex or able flag");

  // Parallel detect leaves one technology bit
  a_fallback_one_bit: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state == vphy_emul_pkg::NEG_RESOLVE && !best[2] && !neg_rerun)
      |=> $onehot(tech_of(partner))
  ) else $error("Parallel detect partner word not one-hot");

  // Forced speed and duplex follow the control bits
  a_forced_mode: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!mac_mode && !neg_en)
      |=> (port0_full_duplex == $past(ctl[vphy_emul_pkg::DUPLEX_MODE_BIT]) &&
           port0_speed_100 == $past(ctl[vphy_emul_pkg::SPEED_SELECT_LSB]))
  ) else $error("Forced speed or duplex not applied");

  // MAC mode duplex follows the pin against the strap
  a_mac_duplex_pin: assert property (
    @(posedge sys_clk) disable iff (srst)
    (mac_mode && neg_en)
      |=> (port0_full_duplex == $past(ext_duplex_indicator == duplex_pol_strap))
  ) else $error("MAC mode duplex does not track the pin");

  // Manual pause writes keep the advertisement
  a_adv_kept: assert property (
    @(posedge sys_clk) disable iff (srst)
    (wr_mp && !block_rst) |=> $stable(adv)
  ) else $error("Manual pause write changed the advertisement");

  // Chip reset bit clears at the end of its hold
  a_hold_clears: assert property (
    @(posedge sys_clk) disable iff (srst)
    (chip_rst_bit && hold_cnt == HOLD_LAST) |=> !chip_rst_bit
  ) else $error("Chip reset bit did not clear after its hold");

  // Complete status precedes page received
  a_done_first: assert property (
    @(posedge sys_clk) disable iff (srst)
    (state == vphy_emul_pkg::NEG_PAGE) |-> neg_done
  ) else $error("Page step reached without complete status");

  // MII management reads in MAC mode return nothing
  a_miim_blocked: assert property (
    @(posedge sys_clk) disable iff (srst)
    (reg_rd && mac_mode && reg_from_miim) |=> (reg_rdata == 16'h0000)
  ) else $error("MII management read reached registers in MAC mode");
endmodule : virtual_phy_autoneg_control

/* File: hdl/vphy_emul_pkg.sv */
// Constants for the emulated single-port PHY control block
package vphy_emul_pkg;
  // Register indexes on the management port
  localparam logic [4:0] EMUL_BASIC_CONTROL_REG = 5'h00;
  localparam logic [4:0] EMUL_BASIC_STATUS_REG  = 5'h01;
  localparam logic [4:0] ADVERTISEMENT_REG      = 5'h04;
  localparam logic [4:0] PARTNER_ABILITY_REG    = 5'h05;
  localparam logic [4:0] NEG_EXPANSION_REG      = 5'h06;
  localparam logic [4:0] PORT0_MANUAL_PAUSE     = 5'h10;
  localparam logic [4:0] CHIP_RESET_CONTROL     = 5'h11;
  // Basic control fields
  localparam int EMUL_SOFT_RESET_BIT = 15;
  localparam int SPEED_SELECT_LSB    = 13;
  localparam int NEG_ENABLE_BIT      = 12;
  localparam int RESTART_NEG_BIT     = 9;
  localparam int DUPLEX_MODE_BIT     = 8;
  // Basic status fields
  localparam int STAT_NEG_ABLE_BIT   = 3;
  localparam int STAT_NEG_DONE_BIT   = 5;
  // Ability fields, shared by advertisement and partner registers
  localparam int ABIL_10HD_BIT       = 5;
  localparam int ABIL_10FD_BIT       = 6;
  localparam int ABIL_100HD_BIT      = 7;
  localparam int ABIL_100FD_BIT      = 8;
  localparam int ABIL_SYM_PAUSE_BIT  = 10;
  localparam int ABIL_ASYM_PAUSE_BIT = 11;
  localparam logic [15:0] ABIL_SELECTOR = 16'h0001;
  // Expansion fields
  localparam int EXP_PARTNER_ABLE_BIT = 0;
  localparam int EXP_PAGE_RCVD_BIT    = 1;
  // Manual pause fields
  localparam int MP_TX_BIT     = 0;
  localparam int MP_RX_BIT     = 1;
  localparam int MP_SELECT_BIT = 2;
  localparam int MP_ACT_FD_BIT = 3;
  localparam int MP_ACT_TX_BIT = 4;
  localparam int MP_ACT_RX_BIT = 5;
  // Chip reset control field
  localparam int CRC_EMUL_RST_BIT = 0;
  // Reset values
  localparam logic [15:0] BASIC_CONTROL_RST = 16'h3100;
  localparam logic [15:0] ADVERTISEMENT_RST = 16'h0de1;
  localparam logic [2:0]  MANUAL_PAUSE_RST  = 3'h0;
  // Timing: self-clearing reset hold
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int EMUL_RST_HOLD_NS  = 102000;
  localparam int EMUL_RST_HOLD_CYC = EMUL_RST_HOLD_NS * 1000 / CLK_PERIOD_PS;
  // Negotiation sequencer states
  typedef enum logic [1:0] {
    NEG_IDLE     = 2'b00,
    NEG_COMPLETE = 2'b01,
    NEG_PAGE     = 2'b10,
    NEG_RESOLVE  = 2'b11
  } neg_state_t;
endpackage : vphy_emul_pkg
